// *** timer_regs.svh ***
// Register offsets, field positions and reset values of the basic timer.
// Assumes a 32-bit register bus with byte addresses and one word per register.
// Notes on behaviour
// - Reads of 8, 16 or 32 bits all return correct register contents.
// - Eight registers decoded at their offsets, all resetting to zero.
// - Control bit 7 set buffers the reload value until an update event.
// - Control bit 3 set clears counter enable at the next update event.
// - Control bit 2 set lets only overflow raise the update flag.
// - Update disable clear: overflow or software update loads the buffered values.
// - Update disable set: no update, shadows held, software update still restarts counting.
// - Control bit 0 enables counting; gating needs it already set.
// - A trigger input may set counter enable without a software write.
// - Control bits 31..8 and 6..4 are reserved and read as zero.
// - Counter counts zero to active reload value, wraps and signals overflow.
// - Internal count enable follows counter enable one clock later.
// - Update event reloads prescaler and reload shadows; it sets the flag except for non-overflow updates with control bit 2 set.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define OFS_CTRL_ONE 6'h00
`define OFS_CTRL_TWO 6'h04
`define OFS_IRQ_DMA 6'h0c
`define OFS_STATUS 6'h10
`define OFS_EVENT 6'h14
`define OFS_COUNTER 6'h24
`define OFS_PRESCALER 6'h28
`define OFS_RELOAD 6'h2c

`define RESET_WORD 32'h0000_0000

`define CR1_BUF 7
`define CR1_SINGLE 3
`define CR1_SRC 2
`define CR1_UPDATE_DISABLE 1
`define CR1_CEN 0
`define CR1_RSV_HI 31
`define CR1_RSV_LO 8
`define CR1_RSV_MID_HI 6
`define CR1_RSV_MID_LO 4
`define CR2_MMS_HI 6
`define CR2_MMS_LO 4
`define IE_UPDATE 0
`define IE_DMA 8
`define SR_UPDATE 0
`define EG_UPDATE 0

`define STRB_WORD 4'hf
`define STRB_LOW 4'h3
`define STRB_HIGH 4'hc

`endif

// *** timer_pkg.sv ***
// Types shared by the timer modules.
// Assumes the bus side uses the response codes of AXI4-Lite.
package timer_pkg;
	typedef enum logic [1:0] {
		RESP_OKAY = 2'h0,
		RESP_SLVERR = 2'h2
	} axi_resp_t;

	typedef struct packed {
		logic reload_buffer_enable;
		logic single_shot_select;
		logic update_source_select;
		logic update_disable;
		logic counter_enable_bit;
	} ctrl_one_t;
endpackage : timer_pkg

// *** timer_if.sv ***
// Link between the register side and the time-base core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface timer_if #(parameter int PSC_W = 16);
	logic count_en;
	logic buffer_en;
	logic update_load;
	logic reinit;
	logic cnt_wr;
	logic [31:0] cnt_wdata;
	logic [PSC_W-1:0] psc_pre;
	logic [31:0] arr_pre;
	logic [31:0] cnt;
	logic overflow;

	modport ctrl (output count_en, buffer_en, update_load, reinit, cnt_wr, cnt_wdata,
		psc_pre, arr_pre, input cnt, overflow);
	modport core (input count_en, buffer_en, update_load, reinit, cnt_wr, cnt_wdata,
		psc_pre, arr_pre, output cnt, overflow);
endinterface : timer_if

// *** timer_core.sv ***
// Prescaler, up counter and shadow registers of the timer.
// Assumes the register side decides update events from the overflow it sees.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_core #(parameter int PSC_W = 16) (
	input wire logic clk,
	input wire logic arst_n,
	timer_if.core tif
);
	logic [PSC_W-1:0] psc_cnt_q;
	logic [PSC_W-1:0] psc_shadow_q;
	logic [31:0] arr_shadow_q;
	logic [31:0] cnt_q;
	logic [31:0] arr_active;
	logic tick;
	logic ovf;

	assign arr_active = tif.buffer_en ? arr_shadow_q : tif.arr_pre;
	assign tick = tif.count_en & (psc_cnt_q == psc_shadow_q);
	assign ovf = tick & (cnt_q == arr_active);
	assign tif.overflow = ovf;
	assign tif.cnt = cnt_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			psc_cnt_q <= '0;
		end else if (tif.reinit) begin
			psc_cnt_q <= '0;
		end else if (tif.count_en) begin
			psc_cnt_q <= tick ? '0 : psc_cnt_q + PSC_W'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= `RESET_WORD;
		end else if (tif.cnt_wr) begin
			cnt_q <= tif.cnt_wdata;
		end else if (tif.reinit || ovf) begin
			cnt_q <= `RESET_WORD;
		end else if (tick) begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			psc_shadow_q <= '0;
			arr_shadow_q <= `RESET_WORD;
		end else if (tif.update_load) begin
			psc_shadow_q <= tif.psc_pre;
			arr_shadow_q <= tif.arr_pre;
		end
	end

	property p_wrap;
		@(posedge clk) disable iff (!arst_n)
		(ovf && !tif.cnt_wr) |=> (cnt_q == 32'h0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_step;
		@(posedge clk) disable iff (!arst_n)
		(tick && !ovf && !tif.reinit && !tif.cnt_wr) |=> (cnt_q == $past(cnt_q) + 32'h1);
	endproperty
	a_step: assert property (p_step) else $error("counter did not step");

	property p_direct;
		@(posedge clk) disable iff (!arst_n)
		(tick && !tif.buffer_en && cnt_q == tif.arr_pre && !tif.cnt_wr) |=> (cnt_q == 32'h0);
	endproperty
	a_direct: assert property (p_direct) else $error("direct reload ignored");

	property p_load;
		@(posedge clk) disable iff (!arst_n)
		tif.update_load |=> (arr_shadow_q == $past(tif.arr_pre))
			&& (psc_shadow_q == $past(tif.psc_pre));
	endproperty
	a_load: assert property (p_load) else $error("shadows not reloaded");

	property p_reinit;
		@(posedge clk) disable iff (!arst_n)
		(tif.reinit && !tif.cnt_wr) |=> (cnt_q == 32'h0) && (psc_cnt_q == '0);
	endproperty
	a_reinit: assert property (p_reinit) else $error("restart missed");
endmodule : timer_core

// *** timer_top.sv ***
// Basic timer with an AXI4-Lite register slave.
// Assumes the slave controller inputs are one-cycle pulses synchronous to CLOCK.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_top import timer_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int PSC_W = 16
) (
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic [2:0] AWPROT,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic [2:0] ARPROT,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic SLAVE_UPDATE,
	input wire logic SLAVE_RESET,
	input wire logic TRIGGER_START,
	input wire logic GATE_OPEN,
	output logic UPDATE_EVENT,
	output logic UPDATE_REQUEST,
	output logic UPDATE_DMA,
	output logic COUNT_ACTIVE
);
	timer_if #(.PSC_W(PSC_W)) tif ();

	// Write channel state
	logic aw_full_q, aw_full_d, aw_ready_q;
	logic w_full_q, w_full_d, w_ready_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	axi_resp_t bresp_q;
	logic aw_hs, w_hs, do_write, wr_hit, strb_ok, wr_en;
	logic [5:0] wr_ofs;
	logic [31:0] wr_mask;

	// Read channel state
	logic rvalid_q, rvalid_d, ar_ready_q;
	logic [31:0] rdata_q, rd_data;
	axi_resp_t rresp_q;
	logic ar_hs, rd_hit;

	// Registers
	ctrl_one_t cr1_q, cr1_d;
	logic [2:0] mms_q;
	logic uie_q, ude_q;
	logic uif_q, uif_d;
	logic [PSC_W-1:0] psc_pre_q;
	logic [31:0] arr_pre_q;
	logic internal_count_enable_q;
	logic update_event_q, update_req_q, update_dma_q;

	// Event logic
	logic wr_ctrl1, wr_ctrl2, wr_ie, wr_sr, wr_eg, wr_cnt, wr_psc, wr_arr;
	logic software_update_trigger, sw_update, update_event, uif_set, ovf;

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [5:0] o;
		o = {a[5:2], 2'h0};
		mapped = (a[ADDR_W-1:6] == '0) && (o == `OFS_CTRL_ONE || o == `OFS_CTRL_TWO
			|| o == `OFS_IRQ_DMA || o == `OFS_STATUS || o == `OFS_EVENT
			|| o == `OFS_COUNTER || o == `OFS_PRESCALER || o == `OFS_RELOAD);
	endfunction : mapped

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] m);
		merge = (old & ~m) | (d & m);
	endfunction : merge

	assign AWREADY = aw_ready_q;
	assign WREADY = w_ready_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = ar_ready_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign UPDATE_EVENT = update_event_q;
	assign UPDATE_REQUEST = update_req_q;
	assign UPDATE_DMA = update_dma_q;
	assign COUNT_ACTIVE = internal_count_enable_q;

	assign aw_hs = AWVALID & aw_ready_q;
	assign w_hs = WVALID & w_ready_q;
	assign do_write = aw_full_q & w_full_q & ~bvalid_q;
	assign aw_full_d = (aw_full_q | aw_hs) & ~do_write;
	assign w_full_d = (w_full_q | w_hs) & ~do_write;
	assign wr_ofs = {aw_addr_q[5:2], 2'h0};
	assign wr_hit = mapped(aw_addr_q);
	assign strb_ok = (w_strb_q == `STRB_WORD) || (w_strb_q == `STRB_LOW)
		|| (w_strb_q == `STRB_HIGH);
	assign wr_en = do_write & wr_hit & strb_ok;
	assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	assign wr_ctrl1 = wr_en && wr_ofs == `OFS_CTRL_ONE;
	assign wr_ctrl2 = wr_en && wr_ofs == `OFS_CTRL_TWO;
	assign wr_ie = wr_en && wr_ofs == `OFS_IRQ_DMA;
	assign wr_sr = wr_en && wr_ofs == `OFS_STATUS;
	assign wr_eg = wr_en && wr_ofs == `OFS_EVENT;
	assign wr_cnt = wr_en && wr_ofs == `OFS_COUNTER;
	assign wr_psc = wr_en && wr_ofs == `OFS_PRESCALER;
	assign wr_arr = wr_en && wr_ofs == `OFS_RELOAD;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_full_q <= 1'b0;
			aw_ready_q <= 1'b0;
			w_full_q <= 1'b0;
			w_ready_q <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			aw_ready_q <= ~aw_full_d;
			w_full_q <= w_full_d;
			w_ready_q <= ~w_full_d;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (aw_hs) begin
			aw_addr_q <= AWADDR;
		end
		if (w_hs) begin
			w_data_q <= WDATA;
			w_strb_q <= WSTRB;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	always_comb begin
		rd_data = `RESET_WORD;
		unique case ({ARADDR[5:2], 2'h0})
			`OFS_CTRL_ONE: begin
				rd_data[`CR1_BUF] = cr1_q.reload_buffer_enable;
				rd_data[`CR1_SINGLE] = cr1_q.single_shot_select;
				rd_data[`CR1_SRC] = cr1_q.update_source_select;
				rd_data[`CR1_UPDATE_DISABLE] = cr1_q.update_disable;
				rd_data[`CR1_CEN] = cr1_q.counter_enable_bit;
			end
			`OFS_CTRL_TWO: rd_data[`CR2_MMS_HI:`CR2_MMS_LO] = mms_q;
			`OFS_IRQ_DMA: begin
				rd_data[`IE_UPDATE] = uie_q;
				rd_data[`IE_DMA] = ude_q;
			end
			`OFS_STATUS: rd_data[`SR_UPDATE] = uif_q;
			`OFS_COUNTER: rd_data = tif.cnt;
			`OFS_PRESCALER: rd_data[PSC_W-1:0] = psc_pre_q;
			`OFS_RELOAD: rd_data = arr_pre_q;
			default: rd_data = `RESET_WORD;
		endcase
	end

	assign ar_hs = ARVALID & ar_ready_q;
	assign rd_hit = mapped(ARADDR);
	assign rvalid_d = (rvalid_q & ~RREADY) | ar_hs;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			rvalid_q <= 1'b0;
			ar_ready_q <= 1'b0;
			rdata_q <= `RESET_WORD;
			rresp_q <= RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			ar_ready_q <= ~rvalid_d;
			if (ar_hs) begin
				rdata_q <= rd_hit ? rd_data : `RESET_WORD;
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Update event sources
	assign ovf = tif.overflow;
	assign software_update_trigger = wr_eg & w_strb_q[0] & w_data_q[`EG_UPDATE];
	assign sw_update = software_update_trigger | SLAVE_UPDATE;
	assign update_event = ~cr1_q.update_disable & (ovf | sw_update);
	assign uif_set = update_event & (ovf | ~cr1_q.update_source_select);

	assign tif.reinit = sw_update | SLAVE_RESET;
	assign tif.update_load = update_event;
	assign tif.count_en = internal_count_enable_q & GATE_OPEN;
	assign tif.buffer_en = cr1_q.reload_buffer_enable;
	assign tif.psc_pre = psc_pre_q;
	assign tif.arr_pre = arr_pre_q;
	assign tif.cnt_wr = wr_cnt;
	assign tif.cnt_wdata = merge(tif.cnt, w_data_q, wr_mask);

	always_comb begin
		cr1_d = cr1_q;
		if (update_event && cr1_q.single_shot_select) begin
			cr1_d.counter_enable_bit = 1'b0;
		end
		if (wr_ctrl1 && w_strb_q[0]) begin
			cr1_d.reload_buffer_enable = w_data_q[`CR1_BUF];
			cr1_d.single_shot_select = w_data_q[`CR1_SINGLE];
			cr1_d.update_source_select = w_data_q[`CR1_SRC];
			cr1_d.update_disable = w_data_q[`CR1_UPDATE_DISABLE];
			cr1_d.counter_enable_bit = w_data_q[`CR1_CEN];
		end
		if (TRIGGER_START) begin
			cr1_d.counter_enable_bit = 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			cr1_q <= '0;
		end else begin
			cr1_q <= cr1_d;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			internal_count_enable_q <= 1'b0;
		end else begin
			internal_count_enable_q <= cr1_q.counter_enable_bit;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			mms_q <= 3'h0;
			uie_q <= 1'b0;
			ude_q <= 1'b0;
			psc_pre_q <= '0;
			arr_pre_q <= `RESET_WORD;
		end else begin
			if (wr_ctrl2 && w_strb_q[0]) begin
				mms_q <= w_data_q[`CR2_MMS_HI:`CR2_MMS_LO];
			end
			if (wr_ie && w_strb_q[0]) begin
				uie_q <= w_data_q[`IE_UPDATE];
			end
			if (wr_ie && w_strb_q[1]) begin
				ude_q <= w_data_q[`IE_DMA];
			end
			if (wr_psc) begin
				psc_pre_q <= PSC_W'(merge({{(32 - PSC_W){1'b0}}, psc_pre_q}, w_data_q, wr_mask));
			end
			if (wr_arr) begin
				arr_pre_q <= merge(arr_pre_q, w_data_q, wr_mask);
			end
		end
	end

	always_comb begin
		uif_d = uif_q;
		if (wr_sr && w_strb_q[0] && !w_data_q[`SR_UPDATE]) begin
			uif_d = 1'b0;
		end
		if (uif_set) begin
			uif_d = 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			uif_q <= 1'b0;
			update_event_q <= 1'b0;
			update_req_q <= 1'b0;
			update_dma_q <= 1'b0;
		end else begin
			uif_q <= uif_d;
			update_event_q <= update_event;
			update_req_q <= uif_d & uie_q;
			update_dma_q <= uif_set & ude_q;
		end
	end
	timer_core #(.PSC_W(PSC_W)) u_core (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.tif(tif)
	);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	property p_rd_ctrl;
		(ar_hs && rd_hit && {ARADDR[5:2], 2'h0} == `OFS_CTRL_ONE)
			|=> (RDATA[`CR1_CEN] == $past(cr1_q.counter_enable_bit)) && RVALID;
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");
	property p_rsv;
		(ar_hs && rd_hit && {ARADDR[5:2], 2'h0} == `OFS_CTRL_ONE) |=> (RDATA[`CR1_RSV_HI:`CR1_RSV_LO]
			== '0) && (RDATA[`CR1_RSV_MID_HI:`CR1_RSV_MID_LO] == 3'h0);
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved control bits not zero");
	property p_unmapped;
		(ar_hs && !rd_hit) |=> (RRESP == RESP_SLVERR) && (RDATA == 32'h0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_byte_wr;
		(do_write && wr_hit && !strb_ok) |=> $stable(arr_pre_q) && $stable(psc_pre_q)
			&& $stable(mms_q) && $stable(uie_q);
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("byte write took effect");
	property p_en_lag;
		$rose(cr1_q.counter_enable_bit) |=> internal_count_enable_q;
	endproperty
	a_en_lag: assert property (p_en_lag) else $error("count enable late");
	property p_single;
		(update_event && cr1_q.single_shot_select && !wr_ctrl1 && !TRIGGER_START)
			|=> !cr1_q.counter_enable_bit ##1 !internal_count_enable_q;
	endproperty
	a_single: assert property (p_single) else $error("single shot kept running");
	property p_sw_single;
		(software_update_trigger && cr1_q.single_shot_select && !cr1_q.update_disable
			&& !TRIGGER_START) |=> !cr1_q.counter_enable_bit;
	endproperty
	a_sw_single: assert property (p_sw_single) else $error("software update kept run");
	property p_src;
		(sw_update && !ovf && cr1_q.update_source_select && !uif_q) |=> !uif_q;
	endproperty
	a_src: assert property (p_src) else $error("flag set by filtered source");
	property p_update;
		(ovf && !cr1_q.update_disable) |=> UPDATE_EVENT && uif_q;
	endproperty
	a_update: assert property (p_update) else $error("overflow gave no update");
	property p_disabled;
		cr1_q.update_disable |=> !UPDATE_EVENT;
	endproperty
	a_disabled: assert property (p_disabled) else $error("update while disabled");
	property p_trigger;
		TRIGGER_START |=> cr1_q.counter_enable_bit ##1 internal_count_enable_q;
	endproperty
	a_trigger: assert property (p_trigger) else $error("trigger did not start");
	property p_idle;
		(!internal_count_enable_q && !tif.cnt_wr && !tif.reinit) |=> $stable(tif.cnt);
	endproperty
	a_idle: assert property (p_idle) else $error("counted while disabled");
endmodule : timer_top

// *** tb_top.sv ***
// Self-checking bench for the basic timer register block.
// Assumes timer_top with default parameters, driven over AXI4-Lite at 250 MHz.
`timescale 1ns/1ps
module tb_top;
	logic CLOCK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic SLAVE_UPDATE, SLAVE_RESET, TRIGGER_START, GATE_OPEN;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [2:0] AWPROT, ARPROT;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic UPDATE_EVENT, UPDATE_REQUEST, UPDATE_DMA, COUNT_ACTIVE;
	logic [1:0] BRESP, RRESP;
	int error_cnt, checked, ev_cnt, dma_cnt;

	timer_top u_dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .AWADDR(AWADDR), .AWPROT(AWPROT),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(ARPROT), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .SLAVE_UPDATE(SLAVE_UPDATE), .SLAVE_RESET(SLAVE_RESET),
		.TRIGGER_START(TRIGGER_START), .GATE_OPEN(GATE_OPEN),
		.UPDATE_EVENT(UPDATE_EVENT), .UPDATE_REQUEST(UPDATE_REQUEST),
		.UPDATE_DMA(UPDATE_DMA), .COUNT_ACTIVE(COUNT_ACTIVE));

	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end

	always @(posedge CLOCK) begin
		if (UPDATE_EVENT === 1'b1) ev_cnt++;
		if (UPDATE_DMA === 1'b1) dma_cnt++;
	end

	task automatic bad(input string m);
		error_cnt++;
		$display("BAD %0t %s", $time, m);
	endtask : bad

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) bad($sformatf("%s got %h want %h", m, got, exp));
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) bad($sformatf("%s got %b want %b", m, got, exp));
	endtask : chk_bit

	// Address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
		input logic [1:0] er = 2'h0);
		logic aw_t;
		logic w_t;
		aw_t = 1'b0;
		w_t = 1'b0;
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		while (!(aw_t && w_t)) begin
			@(posedge CLOCK);
			aw_t = aw_t | (AWREADY === 1'b1);
			w_t = w_t | (WREADY === 1'b1);
			AWVALID <= !aw_t;
			WVALID <= !w_t;
		end
		do @(posedge CLOCK); while (BVALID !== 1'b1);
		chk_word({30'h0, BRESP}, {30'h0, er}, "write response");
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input logic [1:0] er = 2'h0);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge CLOCK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLOCK); while (RVALID !== 1'b1);
		chk_word(RDATA, exp, $sformatf("read %h", a));
		chk_word({30'h0, RRESP}, {30'h0, er}, "read response");
	endtask : rd_chk

	task automatic wait_ev(output int n);
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (UPDATE_EVENT !== 1'b1 && n < 200);
		if (n >= 200) bad("no update event");
	endtask : wait_ev

	// Kind 0 slave update, 1 slave reset, 2 trigger start
	task automatic pulse(input int k);
		@(posedge CLOCK);
		SLAVE_UPDATE <= (k == 0);
		SLAVE_RESET <= (k == 1);
		TRIGGER_START <= (k == 2);
		@(posedge CLOCK);
		{SLAVE_UPDATE, SLAVE_RESET, TRIGGER_START} <= 3'h0;
		repeat (2) @(posedge CLOCK);
	endtask : pulse

	task automatic t_reset;
		logic [11:0] ofs [8] = '{12'h000, 12'h004, 12'h00c, 12'h010, 12'h014, 12'h024,
			12'h028, 12'h02c};
		foreach (ofs[i]) rd_chk(ofs[i], 32'h0);
		rd_chk(12'h008, 32'h0, 2'h2);
		wr(12'h008, 32'h1, 4'hf, 2'h2);
		$display("test reset done");
	endtask : t_reset

	task automatic t_access;
		wr(12'h02c, 32'h0000_1234);
		wr(12'h02c, 32'h0000_ffff, 4'h1);
		rd_chk(12'h02c, 32'h0000_1234);
		wr(12'h02c, 32'hffff_abcd, 4'h3);
		rd_chk(12'h02c, 32'h0000_abcd);
		wr(12'h02c, 32'h5678_0000, 4'hc);
		rd_chk(12'h02c, 32'h5678_abcd);
		wr(12'h000, 32'hffff_fff0);
		rd_chk(12'h000, 32'h0000_0080);
		wr(12'h000, 32'h0);
		$display("test access done");
	endtask : t_access

	task automatic t_period;
		int n;
		wr(12'h028, 32'h0);
		wr(12'h02c, 32'h4);
		wr(12'h014, 32'h1);
		wr(12'h000, 32'h1);
		@(posedge CLOCK);
		chk_bit(COUNT_ACTIVE, 1'b1, "count active");
		wait_ev(n);
		wait_ev(n);
		chk_word(32'(n), 32'd5, "period");
		rd_chk(12'h010, 32'h1);
		wr(12'h000, 32'h0);
		@(posedge CLOCK);
		chk_bit(COUNT_ACTIVE, 1'b0, "count stopped");
		wr(12'h024, 32'h33);
		repeat (10) @(posedge CLOCK);
		rd_chk(12'h024, 32'h33);
		wr(12'h010, 32'h0);
		rd_chk(12'h010, 32'h0);
		$display("test period done");
	endtask : t_period

	task automatic t_buffer;
		int n;
		for (int b = 0; b < 2; b++) begin
			wr(12'h000, 32'(b) << 7);
			wr(12'h02c, 32'h4);
			wr(12'h014, 32'h1);
			wr(12'h02c, 32'h9);
			wr(12'h000, (32'(b) << 7) | 32'h1);
			wait_ev(n);
			chk_bit(n < 10, b[0], "reload taken at update only");
			wait_ev(n);
			chk_word(32'(n), 32'd10, "period after update");
			wr(12'h000, 32'h0);
		end
		$display("test buffer done");
	endtask : t_buffer

	task automatic t_single;
		int n;
		wr(12'h02c, 32'h3);
		wr(12'h024, 32'h0);
		wr(12'h000, 32'h9);
		wait_ev(n);
		rd_chk(12'h000, 32'h8);
		chk_bit(COUNT_ACTIVE, 1'b0, "single shot stop");
		wr(12'h02c, 32'h100);
		wr(12'h000, 32'h9);
		wr(12'h014, 32'h1);
		rd_chk(12'h000, 32'h8);
		wr(12'h000, 32'h0);
		$display("test single done");
	endtask : t_single

	task automatic t_source;
		int d0;
		wr(12'h00c, 32'h101);
		wr(12'h000, 32'h4);
		wr(12'h010, 32'h0);
		d0 = dma_cnt;
		wr(12'h014, 32'h1);
		rd_chk(12'h010, 32'h0);
		chk_bit(UPDATE_REQUEST, 1'b0, "request masked by source");
		chk_word(32'(dma_cnt - d0), 32'h0, "dma masked by source");
		wr(12'h000, 32'h0);
		wr(12'h014, 32'h1);
		rd_chk(12'h010, 32'h1);
		chk_word(32'(dma_cnt - d0), 32'h1, "dma request on update");
		chk_bit(UPDATE_REQUEST, 1'b1, "request raised");
		wr(12'h010, 32'h0);
		chk_bit(UPDATE_REQUEST, 1'b0, "request cleared");
		pulse(0);
		rd_chk(12'h010, 32'h1);
		wr(12'h010, 32'h0);
		wr(12'h00c, 32'h0);
		$display("test source done");
	endtask : t_source

	task automatic t_disable;
		int e0;
		wr(12'h000, 32'h2);
		e0 = ev_cnt;
		wr(12'h024, 32'h55);
		wr(12'h014, 32'h1);
		rd_chk(12'h024, 32'h0);
		rd_chk(12'h010, 32'h0);
		chk_word(32'(ev_cnt - e0), 32'h0, "no update event");
		wr(12'h024, 32'h20);
		pulse(1);
		rd_chk(12'h024, 32'h0);
		wr(12'h000, 32'h0);
		$display("test disable done");
	endtask : t_disable

	task automatic t_trigger;
		wr(12'h02c, 32'h100);
		pulse(2);
		rd_chk(12'h000, 32'h1);
		chk_bit(COUNT_ACTIVE, 1'b1, "trigger starts count");
		wr(12'h000, 32'h0);
		$display("test trigger done");
	endtask : t_trigger

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test

	initial begin
		#80000;
		bad("timeout");
		stop_test;
	end

	initial begin
		ARST_N = 1'b0;
		{AWVALID, WVALID, ARVALID, SLAVE_UPDATE, SLAVE_RESET, TRIGGER_START} = 6'h0;
		{BREADY, RREADY, GATE_OPEN} = 3'h7;
		{AWADDR, ARADDR, AWPROT, ARPROT, WSTRB} = 34'h0;
		WDATA = 32'h0;
		repeat (20) @(posedge CLOCK);
		ARST_N <= 1'b1;
		repeat (2) @(posedge CLOCK);
		t_reset;
		t_access;
		t_period;
		t_buffer;
		t_single;
		t_source;
		t_disable;
		t_trigger;
		stop_test;
	end
endmodule : tb_top
